// ==== core/mts_edge_detect.sv ====
// Rising-edge detector with a short stability filter for a trigger input
`timescale 1ns/10ps
module mts_edge_detect #(
	parameter int LEN = 3                                // Cycles the level must hold
) (
	input  wire logic core_clk,                          // System clock
	input  wire logic rst_n,                             // Async reset, active low
	input  wire logic level_in,                          // Raw active-high level
	output logic      rise_pulse                         // One-cycle pulse on accepted rise
);

	typedef struct packed {
		logic [LEN-1:0] hist;
		logic           stable;
		logic           pulse;
	} mts_edge_type;

	mts_edge_type st_r;
	mts_edge_type st_nxt;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.hist  = {st_r.hist[LEN-2:0], level_in};
		st_nxt.pulse = 1'b0;
		// Level accepted only once it held for LEN cycles, so contact bounce is one event
		if (&st_r.hist && !st_r.stable) begin
			st_nxt.stable = 1'b1;
			st_nxt.pulse  = 1'b1;
		end else if (~|st_r.hist) begin
			st_nxt.stable = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rise_pulse = st_r.pulse;

endmodule : mts_edge_detect

// ==== core/mts_sequencer.sv ====
// Trigger sequencer: decides when each measurement cycle starts
`timescale 1ns/10ps
module mts_sequencer #(
	parameter int FILTER_LEN = mts_pkg::PIN_FILTER_LEN    // Isolated input stability cycles
) (
	input  wire logic core_clk,                           // System clock, 100 MHz
	input  wire logic rst_n,                              // Async reset, active low
	input  wire logic source_sel_wr,                      // Pulse: load source_sel_val
	input  wire logic source_sel_val,                     // 0 internal, 1 external
	input  wire logic remote_cont_wr,                     // Pulse: remote write of continuation
	input  wire logic remote_cont_val,                    // Continuation value from remote
	input  wire logic remote_active,                      // Level: remote control state
	input  wire logic arm_cmd,                            // Pulse: remote arm command
	input  wire logic trigger_key,                        // Pulse: front-panel trigger key
	input  wire logic isolated_trigger_input,             // Level: active low, shorted to common
	input  wire logic remote_trg_cmd,                     // Pulse: remote trigger command
	input  wire logic meas_done,                          // Pulse: measurement finished
	output logic      meas_start,                         // Pulse: begin one measurement
	output logic      meas_abort,                         // Pulse: abort running measurement
	output logic      meas_busy,                          // Level: measurement in progress
	output logic      isolated_trigger_input_armed,                         // Level: waiting for armed trigger
	output logic      source_ext,                         // Level: external source selected
	output logic      continuation_on                     // Level: continuation mode state
);
	import mts_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		mts_state_type state;
		logic          source;
		logic          cont;
		logic          remote_d;
		logic          start;
		logic          abort;
		logic          busy;
		logic          armed;
	} mts_seq_type;

	mts_seq_type st_r;
	mts_seq_type st_nxt;

	// ****************************************
	// Decoded conditions
	// ****************************************
	logic        pin_pulse;

	logic        src_ext;
	logic        in_idle;
	logic        in_armed;
	logic        in_measure;

	logic        pin_or_cmd;
	logic        ext_isolated_trigger_input;
	logic        key_ext;
	logic        key_abort;
	logic        done_ok;

	logic        released;
	logic        cont_write;

	logic        free_run;
	logic        arm_ok;
	logic        ext_start;
	logic        armed_fire;

	// ****************************************
	// Isolated input
	// ****************************************
	// Short to common pulls the pin low; the filter wants an active-high level
	mts_edge_detect #(
		.LEN        (FILTER_LEN)
	) u_pin_edge (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.level_in   (!isolated_trigger_input),
		.rise_pulse (pin_pulse)
	);

	// ****************************************
	// Trigger qualification
	// ****************************************
	assign src_ext    = (st_r.source == SRC_EXTERNAL);
	assign in_idle    = (st_r.state == MTS_IDLE);
	assign in_armed   = (st_r.state == MTS_ARMED);
	assign in_measure = (st_r.state == MTS_MEASURE);

	// Internal source masks every outside trigger at this one point
	assign pin_or_cmd = pin_pulse || remote_trg_cmd;
	assign ext_isolated_trigger_input   = src_ext && pin_or_cmd;
	assign key_ext    = src_ext && trigger_key;

	// With external source, key stops a running measurement; pin and command never do
	assign key_abort  = key_ext && in_measure;
	assign done_ok    = meas_done && in_measure;

	// ****************************************
	// Continuation control
	// ****************************************
	// Falling remote level is the return to local
	assign released   = st_r.remote_d && !remote_active;
	// No local write path exists, so the front panel cannot clear it
	assign cont_write = remote_cont_wr && remote_active;

	// ****************************************
	// Start conditions
	// ****************************************
	assign free_run   = !src_ext && st_r.cont;
	// Arming only means something in single-shot mode from idle
	assign arm_ok     = arm_cmd && !st_r.cont && in_idle;
	assign ext_start  = st_r.cont && (ext_isolated_trigger_input || key_ext);
	// Internal armed state fires itself; external waits for a trigger
	assign armed_fire = in_armed && (!src_ext || ext_isolated_trigger_input || key_ext);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_nxt          = st_r;
		st_nxt.remote_d = remote_active;
		st_nxt.start    = 1'b0;
		st_nxt.abort    = 1'b0;

		// New source choice applies from the next decision
		if (source_sel_wr) begin
			st_nxt.source = source_sel_val;
		end

		if (cont_write) begin
			st_nxt.cont = remote_cont_val;
		end
		// Written last so a return to local beats a same-cycle remote write
		if (released) begin
			st_nxt.cont = 1'b1;
		end

		// One transition per cycle, so one start per accepted trigger
		case (st_r.state)
		MTS_IDLE: begin
			if (free_run) begin
				st_nxt.state = MTS_MEASURE;
				st_nxt.start = 1'b1;
			end else if (ext_start) begin
				st_nxt.state = MTS_MEASURE;
				st_nxt.start = 1'b1;
			end else if (arm_ok) begin
				st_nxt.state = MTS_ARMED;
			end
		end
		MTS_ARMED: begin
			if (armed_fire) begin
				st_nxt.state = MTS_MEASURE;
				st_nxt.start = 1'b1;
			end
		end
		MTS_MEASURE: begin
			// Further pin and command triggers fall through unused
			if (key_abort) begin
				st_nxt.state = MTS_IDLE;
				st_nxt.abort = 1'b1;
			end else if (done_ok) begin
				st_nxt.state = MTS_IDLE;
			end
		end
		default: begin
			// Unused encoding recovers to idle
			st_nxt.state = MTS_IDLE;
		end
		endcase

		// Status levels registered so they change together with the state
		st_nxt.busy  = (st_nxt.state == MTS_MEASURE);
		st_nxt.armed = (st_nxt.state == MTS_ARMED);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			// Power-up restores continuation and the internal source
			st_r.state    <= MTS_IDLE;
			st_r.source   <= RST_SOURCE;
			st_r.cont     <= RST_CONTINUATION;
			st_r.remote_d <= 1'b0;
			st_r.start    <= 1'b0;
			st_r.abort    <= 1'b0;
			st_r.busy     <= 1'b0;
			st_r.armed    <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Start and abort are one-cycle strobes
	assign meas_start      = st_r.start;
	assign meas_abort      = st_r.abort;
	assign meas_busy       = st_r.busy;
	assign isolated_trigger_input_armed      = st_r.armed;
	assign source_ext      = st_r.source;
	assign continuation_on = st_r.cont;

endmodule : mts_sequencer

// ==== shared/mts_pkg.sv ====
// Package of constants and types for the measurement trigger sequencer
package mts_pkg;

	// ****************************************
	// Trigger source selection
	// ****************************************
	localparam logic SRC_INTERNAL = 1'b0;
	localparam logic SRC_EXTERNAL = 1'b1;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic RST_SOURCE       = SRC_INTERNAL;
	localparam logic RST_CONTINUATION = 1'b1;

	// ****************************************
	// Isolated input filter
	// ****************************************
	localparam int PIN_FILTER_LEN = 3;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [1:0] {
		MTS_IDLE,
		MTS_ARMED,
		MTS_MEASURE
	} mts_state_type;

endpackage : mts_pkg

// ==== verif/mts_engine_model.sv ====
// Measurement engine answering each start with one done pulse, unless aborted first
`timescale 1ns/10ps
module mts_engine_model #(
	parameter int DLY = 6                  // Measurement length in cycles
) (
	input wire logic core_clk,          // System clock
	input wire logic rst_n,             // Async reset, active low
	input wire logic meas_start,        // Start strobe from the sequencer
	input wire logic meas_abort,        // Abort strobe from the sequencer
	output logic     meas_done          // One-cycle done pulse
);
	int cnt;
	always @(negedge core_clk or negedge rst_n) begin
		if (!rst_n || meas_abort)
			cnt <= 0;
		else if (meas_start)
			cnt <= DLY;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	// Done only while a measurement runs
	assign meas_done = (cnt == 1);
endmodule : mts_engine_model

// ==== verif/mts_monitor.sv ====
// Port checker for the trigger sequencer
`timescale 1ns/10ps
module mts_monitor (
	input wire logic core_clk,          // System clock
	input wire logic rst_n,             // Async reset, active low
	input wire logic remote_active,     // Remote control level
	input wire logic trigger_key,       // Key press pulse
	input wire logic remote_trg_cmd,    // Remote trigger pulse
	input wire logic meas_done,         // Engine done pulse
	input wire logic meas_start,        // Start strobe
	input wire logic meas_abort,        // Abort strobe
	input wire logic meas_busy,         // Measurement running
	input wire logic isolated_trigger_input_armed,        // Armed level
	input wire logic source_ext,        // External source selected
	input wire logic continuation_on    // Continuation mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_start_once: assert property (meas_start |-> meas_busy ##1 !meas_start) else $error("start");
	a_local_cont: assert property (!remote_active |=> continuation_on) else $error("local");
	a_release_cont: assert property ($fell(remote_active) |=> continuation_on[*2]) else $error("rel");
	a_free_run: assert property ((meas_busy && meas_done && !source_ext) ##1 (!source_ext && continuation_on)
		|-> !meas_busy ##1 meas_start) else $error("free");
	a_arm_once: assert property (isolated_trigger_input_armed && !source_ext |=> meas_start && !isolated_trigger_input_armed) else $error("arm");
	a_ext_trg: assert property (source_ext && continuation_on && !meas_busy && remote_trg_cmd
		|=> meas_start) else $error("trg");
	a_key_abort: assert property (source_ext && meas_busy && trigger_key && !meas_done
		|=> meas_abort && !meas_busy) else $error("abort");
	a_int_ignore: assert property (!source_ext && meas_busy && !meas_done && (trigger_key || remote_trg_cmd)
		|=> !meas_abort && meas_busy) else $error("int");
	a_busy_ignore: assert property (meas_busy && !meas_done && remote_trg_cmd && !trigger_key
		|=> !meas_start) else $error("busy");
endmodule : mts_monitor
bind mts_sequencer mts_monitor u_mon (
	.core_clk        (core_clk),
	.rst_n           (rst_n),
	.remote_active   (remote_active),
	.trigger_key     (trigger_key),
	.remote_trg_cmd  (remote_trg_cmd),
	.meas_done       (meas_done),
	.meas_start      (meas_start),
	.meas_abort      (meas_abort),
	.meas_busy       (meas_busy),
	.isolated_trigger_input_armed      (isolated_trigger_input_armed),
	.source_ext      (source_ext),
	.continuation_on (continuation_on)
);

// ==== verif/mts_sequencer_test.sv ====
// Self-checking bench for the trigger sequencer
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module mts_sequencer_test;
	logic core_clk = 0, rst_n = 0, source_sel_val = 0, remote_cont_val = 0;
	logic remote_active = 0, isolated_trigger_input = 1;
	logic [4:0] pl = 5'h00;
	logic meas_done, meas_start, meas_abort, meas_busy, isolated_trigger_input_armed, source_ext, continuation_on;
	int failures = 0, n_compared = 0, n_start = 0, n_abort = 0, s;
	always #5 core_clk = ~core_clk;
	// Posedge reads see the value registered at the previous edge
	always @(posedge core_clk) begin
		n_start += (meas_start === 1'b1);
		n_abort += (meas_abort === 1'b1);
	end
	mts_sequencer #(.FILTER_LEN(2)) dut (.core_clk, .rst_n, .source_sel_wr(pl[0]), .source_sel_val,
		.remote_cont_wr(pl[1]), .remote_cont_val, .remote_active, .arm_cmd(pl[2]), .trigger_key(pl[3]),
		.isolated_trigger_input, .remote_trg_cmd(pl[4]), .meas_done, .meas_start, .meas_abort,
		.meas_busy, .isolated_trigger_input_armed, .source_ext, .continuation_on);
	mts_engine_model u_eng (.core_clk, .rst_n, .meas_start, .meas_abort, .meas_done);
	task pulse(input logic [4:0] p);
		@(negedge core_clk) pl = p;
		@(negedge core_clk) pl = 5'h00;
	endtask : pulse
	task wait_idle;
		for (int i = 0; i < 40 && meas_busy !== 1'b0; i++) @(negedge core_clk);
	endtask : wait_idle
	task t_reset;
		repeat (2) @(negedge core_clk);
		`CHK("source_ext", 1'b0, source_ext)
		`CHK("continuation_on", 1'b1, continuation_on)
		rst_n = 1;
		repeat (40) @(negedge core_clk);
		`CHK("free run", 1'b1, n_start > 2)
	endtask : t_reset
	task t_ext;
		source_sel_val = 1;
		pulse(5'h01);
		wait_idle;
		s = n_start;
		pulse(5'h10);
		pulse(5'h10);
		wait_idle;
		`CHK("trg", s + 1, n_start)
		pulse(5'h08);
		pulse(5'h08);
		@(negedge core_clk);
		`CHK("abort", 1, n_abort)
		`CHK("busy", 1'b0, meas_busy)
		`CHK("key", s + 2, n_start)
		isolated_trigger_input = 0;
		repeat (6) @(negedge core_clk);
		isolated_trigger_input = 1;
		wait_idle;
		`CHK("pin", s + 3, n_start)
	endtask : t_ext
	task t_single;
		remote_active = 1;
		pulse(5'h02);
		`CHK("cont clr", 1'b0, continuation_on)
		s = n_start;
		pulse(5'h10);
		pulse(5'h04);
		`CHK("armed", 1'b1, isolated_trigger_input_armed)
		pulse(5'h10);
		wait_idle;
		pulse(5'h10);
		wait_idle;
		`CHK("ext one", s + 1, n_start)
		source_sel_val = 0;
		pulse(5'h01);
		pulse(5'h08);
		isolated_trigger_input = 0;
		repeat (9) @(negedge core_clk);
		isolated_trigger_input = 1;
		`CHK("int key", s + 1, n_start)
		pulse(5'h04);
		repeat (12) @(negedge core_clk);
		`CHK("int one", s + 2, n_start)
		remote_active = 0;
		repeat (2) @(negedge core_clk);
		`CHK("cont set", 1'b1, continuation_on)
		pulse(5'h18);
		@(negedge core_clk);
		`CHK("no abort", 1, n_abort)
	endtask : t_single
	task results;
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	initial begin
		t_reset;
		t_ext;
		t_single;
		results;
	end
	initial begin
		#20000;
		failures++;
		results;
	end
endmodule : mts_sequencer_test
